// ===== design/serial_comm_unit.sv
// Device end of the clocked serial link: clock master, full-duplex transmit and receive
//
// Notes on behaviour
// - Independent transmit and receive, one shared clock.
// - Transmit and receive both double buffered.
// - Transmit data changes on serial clock falling edges.
// - Data stable on the line at rising edge.
// - Receiver captures each bit on rising edge.
// - Characters go least significant bit first.
// - Line keeps last bit level after character.
// - Every character is exactly eight bits.
// - No parity, no multiprocessor bit added.
module serial_comm_unit #(
   parameter int HALF_CYCLES = sync_serial_pkg::SCLK_HALF_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_in,
   // Transmit side of the user port
   input wire logic [sync_serial_pkg::CHAR_BITS-1:0] tx_data_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   // Keep clocking frames for reception even with nothing new to send
   input wire logic rx_req_in,
   // Receive side of the user port
   output logic [sync_serial_pkg::CHAR_BITS-1:0] rx_data_out,
   output logic rx_valid_out,
   output logic busy_out,
   // Serial link
   sync_serial_link_if.dev link
);
   import sync_serial_pkg::*;

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   localparam int CNT_W = $clog2(HALF_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_LOW,
      ST_HIGH
   } frame_state_t;

   frame_state_t state_q;
   frame_state_t state_d;
   logic [CNT_W-1:0] half_cnt_q;
   logic [BIT_IDX_W-1:0] bit_q;
   logic [CHAR_BITS-1:0] hold_q;
   logic hold_full_q;
   logic tx_ready_q;
   logic [CHAR_BITS-1:0] tx_sh_q;
   logic tx_act_q;
   logic txd_q;
   logic sclk_q;
   logic rx_meta_q;
   logic rx_sync_q;
   logic [CHAR_BITS-1:0] rx_sh_q;
   logic [CHAR_BITS-1:0] rx_data_q;
   logic rx_valid_q;
   logic busy_q;
   logic tick;
   logic want;
   logic fall;
   logic rise;
   logic new_frame;
   logic frame_end;
   logic accept;
   logic hold_full_d;

   // -------------------------------------------------------------------------
   // Event decode
   // -------------------------------------------------------------------------
   // A half period of the serial clock has run out
   assign tick = (half_cnt_q == CNT_LAST);
   // Another frame is wanted: new data waits, or the user asks to receive
   assign want = hold_full_q | rx_req_in;
   // Serial clock goes low: start of a frame or of the next bit
   assign fall = ((state_q == ST_IDLE) && want) ||
                 ((state_q == ST_HIGH) && tick && ((bit_q != LAST_BIT) || want));
   // Serial clock goes high: the bit on each line is taken
   assign rise = (state_q == ST_LOW) && tick;
   // First falling edge of a character, also the back-to-back case
   assign new_frame = fall && ((state_q == ST_IDLE) || (bit_q == LAST_BIT));
   // Eighth rising edge has passed and its high half is over
   assign frame_end = (state_q == ST_HIGH) && tick && (bit_q == LAST_BIT);
   // Holding buffer takes a character while its ready flag is up
   assign accept = tx_valid_in & tx_ready_q;

   // -------------------------------------------------------------------------
   // Frame sequencer
   // -------------------------------------------------------------------------
   // Next state of the clock generator
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (fall) begin
               state_d = ST_LOW;
            end
         end
         ST_LOW: begin
            if (rise) begin
               state_d = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (fall) begin
               state_d = ST_LOW;
            end else if (frame_end) begin
               state_d = ST_IDLE;
            end
         end
      endcase
   end

   // State register and busy flag
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_q <= ST_IDLE;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         busy_q <= (state_d != ST_IDLE);
      end
   end

   // Half period counter, restarts on every serial clock edge
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         half_cnt_q <= CNT_ZERO;
      end else if (fall || rise || (state_q == ST_IDLE)) begin
         half_cnt_q <= CNT_ZERO;
      end else begin
         half_cnt_q <= half_cnt_q + CNT_W'(1);
      end
   end

   // Bit index; wraps after exactly eight bits
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         bit_q <= FIRST_BIT;
      end else if (new_frame) begin
         bit_q <= FIRST_BIT;
      end else if (fall) begin
         bit_q <= bit_q + 3'h1;
      end
   end

   // Serial clock: one generator drives both directions at once
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sclk_q <= SCLK_IDLE;
      end else if (fall) begin
         sclk_q <= 1'b0;
      end else if (rise) begin
         sclk_q <= 1'b1;
      end
   end

   // -------------------------------------------------------------------------
   // Transmit path
   // -------------------------------------------------------------------------
   // Holding buffer empties when a frame loads it into the shifter
   always_comb begin
      hold_full_d = hold_full_q;
      if (new_frame && hold_full_q) begin
         hold_full_d = 1'b0;
      end else if (accept) begin
         hold_full_d = 1'b1;
      end
   end

   // Holding register: the next character can be written mid-frame
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         hold_q <= CHAR_RESET;
         hold_full_q <= 1'b0;
         tx_ready_q <= 1'b1;
      end else begin
         hold_full_q <= hold_full_d;
         tx_ready_q <= ~hold_full_d;
         if (accept) begin
            hold_q <= tx_data_in;
         end
      end
   end

   // Shifter: loaded at the first falling edge; a receive-only frame sends nothing
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_sh_q <= CHAR_RESET;
         tx_act_q <= 1'b0;
      end else if (new_frame) begin
         tx_act_q <= hold_full_q;
         if (hold_full_q) begin
            tx_sh_q <= hold_q;
         end
      end
   end

   // Line driver: changes only at falling edges, so it is settled for the rise
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         txd_q <= LINE_RESET;
      end else if (new_frame && hold_full_q) begin
         txd_q <= hold_q[0];
      end else if (fall && !new_frame && tx_act_q) begin
         txd_q <= tx_sh_q[bit_q + 3'h1];
      end
      // Otherwise the line keeps the last bit level
   end

   // -------------------------------------------------------------------------
   // Receive path
   // -------------------------------------------------------------------------
   // Incoming line is from the far end, so it is synchronised first.
   // Its latency is well inside half a serial period, so rise sees settled data.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rx_meta_q <= LINE_RESET;
         rx_sync_q <= LINE_RESET;
      end else begin
         rx_meta_q <= link.peer_data;
         rx_sync_q <= rx_meta_q;
      end
   end

   // Receive shifter: first bit ends up at the bottom
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rx_sh_q <= CHAR_RESET;
      end else if (rise) begin
         rx_sh_q <= {rx_sync_q, rx_sh_q[CHAR_BITS-1:1]};
      end
   end

   // Receive buffer: the last character stays readable while the next shifts in
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rx_data_q <= CHAR_RESET;
         rx_valid_q <= 1'b0;
      end else begin
         rx_valid_q <= frame_end;
         if (frame_end) begin
            rx_data_q <= rx_sh_q;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   // All straight from flip-flops
   assign tx_ready_out = tx_ready_q;
   assign rx_data_out = rx_data_q;
   assign rx_valid_out = rx_valid_q;
   assign busy_out = busy_q;
   assign link.sclk = sclk_q;
   assign link.dev_data = txd_q;

endmodule

// ===== design/sync_serial_link_if.sv
// Link wires between the device end and the peer end of the clocked serial link
interface sync_serial_link_if;

   // Serial clock, made by the device end, idles high
   logic sclk;
   // Data from device end to peer end
   logic dev_data;
   // Data from peer end to device end
   logic peer_data;

   modport dev (
      output sclk,
      output dev_data,
      input peer_data
   );

   modport peer (
      input sclk,
      input dev_data,
      output peer_data
   );

endinterface

// ===== design/sync_serial_peer.sv
// Peer end of the clocked serial link: follows the device's serial clock
module sync_serial_peer (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [sync_serial_pkg::CHAR_BITS-1:0] tx_data_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   output logic [sync_serial_pkg::CHAR_BITS-1:0] rx_data_out,
   output logic rx_valid_out,
   sync_serial_link_if.peer link
);
   import sync_serial_pkg::*;

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   logic sclk_meta_q;
   logic sclk_sync_q;
   logic sclk_prev_q;
   logic dat_meta_q;
   logic dat_sync_q;
   logic [BIT_IDX_W-1:0] bit_q;
   logic [CHAR_BITS-1:0] hold_q;
   logic hold_full_q;
   logic tx_ready_q;
   logic [CHAR_BITS-1:0] tx_sh_q;
   logic tx_act_q;
   logic txd_q;
   logic [CHAR_BITS-1:0] rx_sh_q;
   logic [CHAR_BITS-1:0] rx_data_q;
   logic rx_valid_q;
   logic fall;
   logic rise;
   logic load;
   logic accept;
   logic hold_full_d;

   // -------------------------------------------------------------------------
   // Link sampling
   // -------------------------------------------------------------------------
   // Clock and data both come from another domain; edges are found after sync
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sclk_meta_q <= SCLK_IDLE;
         sclk_sync_q <= SCLK_IDLE;
         sclk_prev_q <= SCLK_IDLE;
         dat_meta_q <= LINE_RESET;
         dat_sync_q <= LINE_RESET;
      end else begin
         sclk_meta_q <= link.sclk;
         sclk_sync_q <= sclk_meta_q;
         sclk_prev_q <= sclk_sync_q;
         dat_meta_q <= link.dev_data;
         dat_sync_q <= dat_meta_q;
      end
   end

   assign fall = sclk_prev_q & ~sclk_sync_q;
   assign rise = ~sclk_prev_q & sclk_sync_q;
   // No frame marker: the first falling edge after reset starts character framing
   assign load = fall && (bit_q == FIRST_BIT);
   assign accept = tx_valid_in & tx_ready_q;

   // Bit index counts rising edges, eight to a character
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         bit_q <= FIRST_BIT;
      end else if (rise) begin
         bit_q <= bit_q + 3'h1;
      end
   end

   // -------------------------------------------------------------------------
   // Transmit path
   // -------------------------------------------------------------------------
   always_comb begin
      hold_full_d = hold_full_q;
      if (load && hold_full_q) begin
         hold_full_d = 1'b0;
      end else if (accept) begin
         hold_full_d = 1'b1;
      end
   end

   // Holding register and shifter
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         hold_q <= CHAR_RESET;
         hold_full_q <= 1'b0;
         tx_ready_q <= 1'b1;
         tx_sh_q <= CHAR_RESET;
         tx_act_q <= 1'b0;
      end else begin
         hold_full_q <= hold_full_d;
         tx_ready_q <= ~hold_full_d;
         if (accept) begin
            hold_q <= tx_data_in;
         end
         if (load) begin
            tx_act_q <= hold_full_q;
            if (hold_full_q) begin
               tx_sh_q <= hold_q;
            end
         end
      end
   end

   // Line changes after a falling edge and is settled before the next rise
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         txd_q <= LINE_RESET;
      end else if (load && hold_full_q) begin
         txd_q <= hold_q[0];
      end else if (fall && !load && tx_act_q) begin
         txd_q <= tx_sh_q[bit_q];
      end
   end

   // -------------------------------------------------------------------------
   // Receive path
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rx_sh_q <= CHAR_RESET;
         rx_data_q <= CHAR_RESET;
         rx_valid_q <= 1'b0;
      end else begin
         rx_valid_q <= rise && (bit_q == LAST_BIT);
         if (rise) begin
            rx_sh_q <= {dat_sync_q, rx_sh_q[CHAR_BITS-1:1]};
         end
         if (rise && (bit_q == LAST_BIT)) begin
            rx_data_q <= {dat_sync_q, rx_sh_q[CHAR_BITS-1:1]};
         end
      end
   end

   // Outputs straight from flip-flops
   assign tx_ready_out = tx_ready_q;
   assign rx_data_out = rx_data_q;
   assign rx_valid_out = rx_valid_q;
   assign link.peer_data = txd_q;

endmodule

// ===== design/sync_serial_pkg.sv
// Shared constants for the clocked serial link and its two ends
package sync_serial_pkg;

   // -------------------------------------------------------------------------
   // Character format
   // -------------------------------------------------------------------------
   // Fixed character length, no parity and no multiprocessor bit
   localparam int CHAR_BITS = 8;
   localparam int BIT_IDX_W = 3;
   localparam logic [BIT_IDX_W-1:0] FIRST_BIT = 3'h0;
   localparam logic [BIT_IDX_W-1:0] LAST_BIT = 3'h7;

   // -------------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   // Half period of the serial clock that the device end generates
   localparam int SCLK_HALF_NS = 320;
   // Least time, so rounded up to whole cycles
   localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // -------------------------------------------------------------------------
   // Values after reset
   // -------------------------------------------------------------------------
   localparam logic SCLK_IDLE = 1'b1;
   localparam logic LINE_RESET = 1'b1;
   localparam logic [CHAR_BITS-1:0] CHAR_RESET = 8'h00;

endpackage

// ===== testbench/clocked_serial_sync_mode_bench.sv
// Self-checking bench: device end and peer end joined across the serial link
module clocked_serial_sync_mode_bench;
   import sync_serial_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [CHAR_BITS-1:0] d_tx_data = 8'h00;
   logic d_tx_valid = 1'b0;
   logic d_rx_req = 1'b0;
   logic [CHAR_BITS-1:0] p_tx_data = 8'h00;
   logic p_tx_valid = 1'b0;
   logic d_tx_ready, d_rx_valid, d_busy, p_tx_ready, p_rx_valid, sclk_q;
   logic [CHAR_BITS-1:0] d_rx_data, p_rx_data;
   logic dev_bits[$];
   logic peer_bits[$];
   logic [CHAR_BITS-1:0] dev_rxq[$];
   logic [CHAR_BITS-1:0] peer_rxq[$];
   int bad_count = 0;
   int tests_run = 0;
   logic [CHAR_BITS-1:0] dv[4] = '{8'h01, 8'h80, 8'ha5, 8'h3c};
   logic [CHAR_BITS-1:0] pv[4] = '{8'hfe, 8'h7f, 8'h5a, 8'hc3};

   sync_serial_link_if link_w();

   serial_comm_unit #(.HALF_CYCLES(8)) serial_comm_unit_inst (.clk_in(clk_in), .rst_in(rst_in),
      .tx_data_in(d_tx_data), .tx_valid_in(d_tx_valid), .tx_ready_out(d_tx_ready), .rx_req_in(d_rx_req),
      .rx_data_out(d_rx_data), .rx_valid_out(d_rx_valid), .busy_out(d_busy), .link(link_w));
   sync_serial_peer sync_serial_peer_inst (.clk_in(clk_in), .rst_in(rst_in), .tx_data_in(p_tx_data),
      .tx_valid_in(p_tx_valid), .tx_ready_out(p_tx_ready), .rx_data_out(p_rx_data),
      .rx_valid_out(p_rx_valid), .link(link_w));
   clocked_serial_sync_mode_chk #(.HALF_CYCLES(8)) clocked_serial_sync_mode_chk_inst (.clk_in(clk_in),
      .rst_in(rst_in), .sclk(link_w.sclk), .dev_data(link_w.dev_data), .peer_data(link_w.peer_data));

   // Clock
   always #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;

   // Monitor: wire bits at each rising serial edge, and every received character
   always @(posedge clk_in) begin
      sclk_q <= link_w.sclk;
      if (link_w.sclk === 1'b1 && sclk_q === 1'b0) begin
         dev_bits.push_back(link_w.dev_data);
         peer_bits.push_back(link_w.peer_data);
      end
      if (d_rx_valid === 1'b1) dev_rxq.push_back(d_rx_data);
      if (p_rx_valid === 1'b1) peer_rxq.push_back(p_rx_data);
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [CHAR_BITS-1:0] seen, input logic [CHAR_BITS-1:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Reset both ends together; values are looked at while reset is still held
   task automatic do_reset();
      @(posedge clk_in);
      rst_in <= 1'b1;
      // Five edges with reset high, counting the release edge
      repeat (4) @(posedge clk_in);
      #1;
      check({link_w.sclk, link_w.dev_data, link_w.peer_data, d_tx_ready, p_tx_ready, d_busy, d_rx_valid,
         p_rx_valid}, {SCLK_IDLE, LINE_RESET, LINE_RESET, 5'h18});
      check(d_rx_data, CHAR_RESET);
      check(p_rx_data, CHAR_RESET);
      @(posedge clk_in);
      rst_in <= 1'b0;
      dev_bits.delete();
      peer_bits.delete();
      dev_rxq.delete();
      peer_rxq.delete();
   endtask

   // Offer a character on one end (0 device, 1 peer); held until taken at an edge with ready high
   task automatic put(input bit sel, input logic [CHAR_BITS-1:0] b);
      int n;
      n = 0;
      @(posedge clk_in);
      if (sel) begin
         p_tx_data <= b;
         p_tx_valid <= 1'b1;
      end else begin
         d_tx_data <= b;
         d_tx_valid <= 1'b1;
      end
      do begin
         @(posedge clk_in);
         n++;
      end while ((sel ? p_tx_ready : d_tx_ready) !== 1'b1 && n < 600);
      if (sel) begin
         p_tx_valid <= 1'b0;
      end else begin
         d_tx_valid <= 1'b0;
      end
      // A holding buffer that never frees up is a hang, so it counts as a mismatch
      if ((sel ? p_tx_ready : d_tx_ready) !== 1'b1) begin
         bad_count++;
         $display("ERROR at %0t: character %h never taken", $time, b);
      end
   endtask

   // Wait for the next character received by one end and compare it
   task automatic take(input bit sel, input logic [CHAR_BITS-1:0] exp);
      int n;
      n = 0;
      while ((sel ? peer_rxq.size() : dev_rxq.size()) == 0 && n < 600) begin
         @(posedge clk_in);
         n++;
      end
      check(sel ? peer_rxq.pop_front() : dev_rxq.pop_front(), exp);
   endtask

   // Rebuild a character from the wire bits, first bit seen as bit 0
   task automatic wire_chk(input bit sel, input logic [CHAR_BITS-1:0] exp);
      logic [CHAR_BITS-1:0] v;
      for (int i = 0; i < CHAR_BITS; i++) v[i] = sel ? peer_bits.pop_front() : dev_bits.pop_front();
      check(v, exp);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      do_reset();
      // Full duplex, two characters back to back each way, loaded while the link is busy
      for (int i = 0; i < 4; i += 2) begin
         put(1'b1, pv[i]);
         put(1'b0, dv[i]);
         put(1'b1, pv[i+1]);
         put(1'b0, dv[i+1]);
         for (int j = i; j < i + 2; j++) begin
            take(1'b1, dv[j]);
            take(1'b0, pv[j]);
            wire_chk(1'b0, dv[j]);
            wire_chk(1'b1, pv[j]);
         end
      end
      // Receive-only frame: the device line must stay at the last bit sent, here 0
      put(1'b1, 8'h96);
      @(posedge clk_in);
      d_rx_req <= 1'b1;
      for (int n = 0; n < 100 && d_busy !== 1'b1; n++) @(posedge clk_in);
      d_rx_req <= 1'b0;
      take(1'b0, 8'h96);
      take(1'b1, 8'h00);
      wire_chk(1'b0, 8'h00);
      wire_chk(1'b1, 8'h96);
      // Peer has nothing loaded: its line keeps the last bit of 8'h96
      put(1'b0, 8'h69);
      take(1'b1, 8'h69);
      take(1'b0, 8'hff);
      wire_chk(1'b0, 8'h69);
      wire_chk(1'b1, 8'hff);
      // Reset in mid-frame, then one more exchange after both ends restart
      put(1'b0, 8'h55);
      repeat (40) @(posedge clk_in);
      do_reset();
      put(1'b1, 8'haa);
      put(1'b0, 8'h0f);
      take(1'b1, 8'h0f);
      take(1'b0, 8'haa);
      wire_chk(1'b0, 8'h0f);
      wire_chk(1'b1, 8'haa);
      wrap_up();
   end

   // Watchdog: the sequence needs about 1,000 cycles
   initial begin
      #(CLK_PERIOD_NS * 20000);
      bad_count++;
      wrap_up();
   end
endmodule

// ===== testbench/clocked_serial_sync_mode_chk.sv
// Concurrent checks on the three wires between the device end and the peer end
module clocked_serial_sync_mode_chk #(
   parameter int HALF_CYCLES = 8
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic sclk,
   input wire logic dev_data,
   input wire logic peer_data
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Helper logic
   // ---------------------------------------------------------------
   logic sclk_q;
   logic [3:0] hi_run_q;
   logic [2:0] rise_cnt_q;
   logic last_bit_q;

   // Length of the current high run of the serial clock, saturating
   always_ff @(posedge clk_in) begin
      if (rst_in || !sclk) begin
         hi_run_q <= 4'h0;
      end else if (hi_run_q != 4'hf) begin
         hi_run_q <= hi_run_q + 4'h1;
      end
   end

   // Rising edges counted modulo one character; the eighth one latches the last bit
   always_ff @(posedge clk_in) begin
      sclk_q <= sclk;
      if (rst_in) begin
         rise_cnt_q <= 3'h0;
         last_bit_q <= 1'b1;
      end else if (sclk && !sclk_q) begin
         rise_cnt_q <= rise_cnt_q + 3'h1;
         if (rise_cnt_q == 3'h7) begin
            last_bit_q <= dev_data;
         end
      end
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // Each half of a serial clock period is a fixed run of system cycles
   sequence s_low_half;
      (!sclk) [*8] ##1 sclk;
   endsequence
   sequence s_high_half;
      sclk [*8];
   endsequence

   property p_tx_on_fall;
      $changed(dev_data) |-> $fell(sclk);
   endproperty
   property p_tx_hold;
      $fell(sclk) |=> $stable(dev_data) [*8];
   endproperty
   property p_low_half;
      $fell(sclk) |-> s_low_half;
   endproperty
   property p_high_half;
      $rose(sclk) |-> s_high_half;
   endproperty
   property p_peer_in_low;
      $changed(peer_data) |-> !sclk;
   endproperty
   property p_peer_hold;
      $rose(sclk) |-> $stable(peer_data) [*8];
   endproperty
   // Idle is only reached on a whole character boundary
   property p_whole_char;
      (hi_run_q == HALF_CYCLES + 1) |-> (rise_cnt_q == 3'h0);
   endproperty
   property p_msb_hold;
      (hi_run_q == HALF_CYCLES + 1) |-> (dev_data == last_bit_q);
   endproperty

   a_tx_on_fall: assert property (p_tx_on_fall) else $error("device data moved off a falling clock edge");
   a_tx_hold: assert property (p_tx_hold) else $error("device data not held through rising edge");
   a_low_half: assert property (p_low_half) else $error("serial clock low half has wrong length");
   a_high_half: assert property (p_high_half) else $error("serial clock high half has wrong length");
   a_peer_in_low: assert property (p_peer_in_low) else $error("peer data moved while clock high");
   a_peer_hold: assert property (p_peer_hold) else $error("peer data not held through rising edge");
   a_whole_char: assert property (p_whole_char) else $error("frame ended off a character boundary");
   a_msb_hold: assert property (p_msb_hold) else $error("idle line left the last bit level");

   c_idle_after_frame: cover property ((rise_cnt_q == 3'h0) && (hi_run_q == HALF_CYCLES + 1));
endmodule
